// [fadm_capture.sv]
// Purpose: far-side capture logic that latches each bank on its ready strobe
// Assumes: bank words are settled when their ready strobe rises
// Notes: behavioural; one capture register per bank, no reset of its own
`timescale 1ns/100ps

module fadm_capture (
   input  wire logic                 rdy_a,
   input  wire logic                 rdy_b,
   input  wire fadm_pkg::fadm_word_t bank_a,
   input  wire fadm_pkg::fadm_word_t bank_b,
   output fadm_pkg::fadm_word_t      cap_a,
   output fadm_pkg::fadm_word_t      cap_b
);
   // ready rising edge is the only capture point
   always_ff @(posedge rdy_a) begin
      cap_a <= bank_a;
   end

   always_ff @(posedge rdy_b) begin
      cap_b <= bank_b;
   end
endmodule

// [fadm_output_demux.sv]
// Purpose: latch, decode, format and bank the flash comparator results
// Assumes: enc_clk is the encode command; comparators settle before its edge
// Notes: ready strobes use the falling encode edge as the cycle midpoint
`timescale 1ns/100ps

module fadm_output_demux (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic                              enc_clk,
   input  wire logic [fadm_pkg::COMP_COUNT-1:0]   comp_in,
   input  wire logic                              msb_flip_control,
   input  wire logic                              low_bits_flip_control,
   input  wire logic                              split_mode,
   output fadm_pkg::fadm_word_t                   bank_a,
   output fadm_pkg::fadm_word_t                   bank_b,
   output logic [fadm_pkg::STACK_W-1:0]           stack_a,
   output logic [fadm_pkg::STACK_W-1:0]           stack_b,
   output logic                                   rdy_a,
   output logic                                   rdy_b,
   output fadm_pkg::fadm_fmt_t                    out_format,
   output logic                                   ovf_pulse
);
   // encode-domain reset, carried over from the system clock as a level
   logic enc_rst_s1_reg;
   logic enc_rst_reg;

   // filtered control pins
   logic [fadm_pkg::CTL_W-1:0] ctl_raw;
   logic [fadm_pkg::CTL_W-1:0] ctl_bits;
   fadm_pkg::fadm_ctl_t        ctl;

   // sample and decode
   logic [fadm_pkg::COMP_COUNT-1:0] comp_reg;
   logic                            cvalid_reg;
   logic [fadm_pkg::DATA_W-1:0]     acc [0:fadm_pkg::OVF_COMP];
   fadm_pkg::fadm_word_t            raw_word;
   fadm_pkg::fadm_word_t            fmt_word;
   logic [fadm_pkg::DATA_W-1:0]     flip_mask;

   // banking
   fadm_pkg::fadm_word_t bank_a_reg;
   fadm_pkg::fadm_word_t bank_a_next;
   fadm_pkg::fadm_word_t bank_b_reg;
   fadm_pkg::fadm_word_t bank_b_next;
   fadm_pkg::fadm_bank_t sel_reg;
   fadm_pkg::fadm_bank_t sel_next;
   fadm_pkg::fadm_bank_t last_bank_reg;
   fadm_pkg::fadm_bank_t last_bank_next;
   fadm_pkg::fadm_fmt_t  fmt_reg;
   fadm_pkg::fadm_fmt_t  fmt_next;
   logic                 wvalid_reg;
   logic                 pos_tog_reg;
   logic                 ovf_tog_reg;
   logic                 ovf_tog_next;
   wire                  load_w;
   wire                  to_a_w;
   wire                  to_b_w;

   // midpoint copies on the falling encode edge
   logic                 neg_tog_reg;
   logic                 neg_valid_reg;
   fadm_pkg::fadm_bank_t neg_bank_reg;
   wire                  rdy_split_a_w;
   wire                  rdy_split_b_w;
   wire                  rdy_single_w;

   // system-clock side of the overflow event
   logic ovf_tog_f;
   logic ovf_seen_reg;
   logic ovf_pulse_reg;
   wire  ovf_event_w;

   always_ff @(posedge enc_clk) begin
      enc_rst_s1_reg <= rst_n;
      enc_rst_reg    <= enc_rst_s1_reg;
   end

   assign ctl_raw[fadm_pkg::PIN_MSB]   = msb_flip_control;
   assign ctl_raw[fadm_pkg::PIN_LOW]   = low_bits_flip_control;
   assign ctl_raw[fadm_pkg::PIN_SPLIT] = split_mode;

   fadm_pin_sync #(
      .W   (fadm_pkg::CTL_W),
      .RST (fadm_pkg::CTL_RST)
   ) u_ctl_sync (
      .clk     (enc_clk),
      .rst_n   (enc_rst_reg),
      .pin_in  (ctl_raw),
      .pin_out (ctl_bits)
   );

   assign ctl.msb_flip = ctl_bits[fadm_pkg::PIN_MSB];
   assign ctl.low_flip = ctl_bits[fadm_pkg::PIN_LOW];
   assign ctl.split    = ctl_bits[fadm_pkg::PIN_SPLIT];

   // latch every comparator at the encode edge
   always_ff @(posedge enc_clk) begin
      if (!enc_rst_reg) begin
         comp_reg   <= '0;
         cvalid_reg <= 1'b0;
      end else begin
         comp_reg   <= comp_in;
         cvalid_reg <= 1'b1;
      end
   end

   // thermometer to binary: top transition gives the code
   assign acc[0] = '0;
   for (genvar i = 0; i < fadm_pkg::OVF_COMP; i++) begin : g_dec
      wire top_w = (i == fadm_pkg::OVF_COMP - 1) ? 1'b1 : ~comp_reg[i+1];
      wire edge_w = comp_reg[i] & top_w;
      assign acc[i+1] = acc[i] | (edge_w ? fadm_pkg::DATA_W'(i + 1) : '0);
   end

   assign raw_word.data = acc[fadm_pkg::OVF_COMP];
   assign raw_word.ovf  = comp_reg[fadm_pkg::OVF_COMP];

   // output format by selective inversion
   assign flip_mask = {ctl.msb_flip, {fadm_pkg::LOW_W{ctl.low_flip}}};
   assign fmt_word.data = raw_word.data ^ flip_mask;
   assign fmt_word.ovf  = raw_word.ovf;
   assign fmt_next = fadm_pkg::fadm_fmt_t'({ctl.low_flip, ctl.msb_flip});

   // one stage after the sample latch gives a single encode of delay
   assign load_w = cvalid_reg;
   assign to_a_w = load_w & (~ctl.split | (sel_reg == fadm_pkg::FADM_BANK_A));
   assign to_b_w = load_w & ctl.split & (sel_reg == fadm_pkg::FADM_BANK_B);

   // alternate banks, B first so a pair is sample N-1 then N
   assign sel_next = (load_w & ctl.split) ?
                     ((sel_reg == fadm_pkg::FADM_BANK_A) ? fadm_pkg::FADM_BANK_B
                                                         : fadm_pkg::FADM_BANK_A)
                     : fadm_pkg::FADM_BANK_B;
   assign last_bank_next = to_b_w ? fadm_pkg::FADM_BANK_B :
                           (to_a_w ? fadm_pkg::FADM_BANK_A : last_bank_reg);
   assign bank_a_next = to_a_w ? fmt_word : bank_a_reg;
   assign bank_b_next = to_b_w ? fmt_word : bank_b_reg;
   assign ovf_tog_next = ovf_tog_reg ^ (load_w & fmt_word.ovf);

   always_ff @(posedge enc_clk) begin
      if (!enc_rst_reg) begin
         bank_a_reg    <= fadm_pkg::WORD_RST;
         bank_b_reg    <= fadm_pkg::WORD_RST;
         sel_reg       <= fadm_pkg::FADM_BANK_B;
         last_bank_reg <= fadm_pkg::FADM_BANK_A;
         fmt_reg       <= fadm_pkg::FMT_OFFSET_BIN;
         wvalid_reg    <= 1'b0;
         pos_tog_reg   <= 1'b0;
         ovf_tog_reg   <= 1'b0;
      end else begin
         bank_a_reg    <= bank_a_next;
         bank_b_reg    <= bank_b_next;
         sel_reg       <= sel_next;
         last_bank_reg <= last_bank_next;
         fmt_reg       <= fmt_next;
         wvalid_reg    <= wvalid_reg | load_w;
         pos_tog_reg   <= pos_tog_reg ^ load_w;
         ovf_tog_reg   <= ovf_tog_next;
      end
   end

   // falling edge marks the cycle midpoint for the strobes
   always_ff @(negedge enc_clk) begin
      if (!enc_rst_reg) begin
         neg_tog_reg   <= 1'b0;
         neg_valid_reg <= 1'b0;
         neg_bank_reg  <= fadm_pkg::FADM_BANK_A;
      end else begin
         neg_tog_reg   <= pos_tog_reg;
         neg_valid_reg <= wvalid_reg;
         neg_bank_reg  <= last_bank_reg;
      end
   end

   // split: high midpoint to midpoint; single: midpoint to next encode
   assign rdy_split_a_w = neg_valid_reg & (neg_bank_reg == fadm_pkg::FADM_BANK_A);
   assign rdy_split_b_w = neg_valid_reg & (neg_bank_reg == fadm_pkg::FADM_BANK_B);
   assign rdy_single_w  = neg_valid_reg & (neg_tog_reg == pos_tog_reg);
   assign rdy_a = ctl.split ? rdy_split_a_w : rdy_single_w;
   assign rdy_b = ctl.split & rdy_split_b_w;

   assign bank_a     = bank_a_reg;
   assign bank_b     = bank_b_reg;
   assign stack_a    = {bank_a_reg.ovf, bank_a_reg.data};
   assign stack_b    = {bank_b_reg.ovf, bank_b_reg.data};
   assign out_format = fmt_reg;

   // overflow event into the system clock
   fadm_pin_sync #(
      .W   (1),
      .RST (1'b0)
   ) u_ovf_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .pin_in  (ovf_tog_reg),
      .pin_out (ovf_tog_f)
   );

   assign ovf_event_w = ovf_tog_f ^ ovf_seen_reg;
   assign ovf_pulse   = ovf_pulse_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovf_seen_reg  <= 1'b0;
         ovf_pulse_reg <= 1'b0;
      end else begin
         ovf_seen_reg  <= ovf_tog_f;
         ovf_pulse_reg <= ovf_event_w;
      end
   end

   // ---------------- checks ----------------

   sequence split_run_s;
      ctl.split && $past(ctl.split) && $past(ctl.split, 2);
   endsequence

   sequence single_run_s;
      !ctl.split && $past(!ctl.split) && $past(!ctl.split, 2);
   endsequence

   sequence load_a_s;
      split_run_s ##0 (load_w && sel_reg == fadm_pkg::FADM_BANK_A);
   endsequence

   sequence ready_pulse_s;
      rdy_split_a_w ##1 !rdy_split_a_w;
   endsequence

   sequence ready_b_pulse_s;
      rdy_split_b_w ##1 !rdy_split_b_w;
   endsequence

   sequence load_b_s;
      split_run_s ##0 (load_w && sel_reg == fadm_pkg::FADM_BANK_B);
   endsequence

   comp_latch_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      $past(enc_rst_reg) |-> comp_reg == $past(comp_in))
      else $error("comparator latch does not match sampled inputs");

   ovf_full_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      comp_reg[fadm_pkg::OVF_COMP] |-> raw_word.ovf && raw_word.data == fadm_pkg::FULL_CODE)
      else $error("overflow input not decoded as full scale with flag");

   pipe_delay_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      single_run_s ##0 (wvalid_reg && $past(cvalid_reg)) |->
         bank_a.ovf == $past(comp_in[fadm_pkg::OVF_COMP], 2))
      else $error("single port word not two encode edges after its sample");

   bank_alternate_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      split_run_s ##0 load_w ##1 (ctl.split && load_w) |=>
         last_bank_reg != $past(last_bank_reg))
      else $error("split banks not loaded alternately");

   pair_order_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      split_run_s ##0 ($past(load_w, 2) && $past(load_w, 3) &&
         last_bank_reg == fadm_pkg::FADM_BANK_A) |->
         bank_a.ovf == $past(comp_in[fadm_pkg::OVF_COMP], 2) &&
         bank_b.ovf == $past(comp_in[fadm_pkg::OVF_COMP], 3))
      else $error("bank B does not hold the earlier sample of the pair");

   bank_hold_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      load_a_s ##1 ctl.split |=> $stable(bank_a))
      else $error("split bank A changed before two encode cycles");

   ready_width_a: assert property (
      @(negedge enc_clk) disable iff (!enc_rst_reg)
      (ctl.split && $past(ctl.split) && !rdy_split_a_w && neg_valid_reg &&
         last_bank_reg == fadm_pkg::FADM_BANK_A) |=> ready_pulse_s)
      else $error("split ready not high for exactly one encode cycle");

   single_replace_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      (!ctl.split && load_w) |=> (ctl.split || (bank_a == $past(fmt_word) && !rdy_b)))
      else $error("single port word not replaced at the encode edge");

   single_high_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      single_run_s ##0 (neg_valid_reg && $past(neg_valid_reg)) |-> rdy_a)
      else $error("single port ready low before the encode edge");

   single_low_a: assert property (
      @(negedge enc_clk) disable iff (!enc_rst_reg)
      (!ctl.split && $past(!ctl.split) && neg_valid_reg) |-> !rdy_a)
      else $error("single port ready high in first half cycle");

   msb_flip_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      (!ctl.split && load_w) |=>
         bank_a.data[fadm_pkg::MSB_POS] ==
            ($past(raw_word.data[fadm_pkg::MSB_POS]) ^ $past(ctl.msb_flip)))
      else $error("top data bit inversion wrong");

   low_flip_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      (!ctl.split && load_w) |=>
         bank_a.data[fadm_pkg::LOW_W-1:0] ==
            ($past(raw_word.data[fadm_pkg::LOW_W-1:0]) ^ {fadm_pkg::LOW_W{$past(ctl.low_flip)}}))
      else $error("low data bits inversion wrong");

   format_code_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      $past(enc_rst_reg) |->
         ((out_format == fadm_pkg::FMT_TWOS_COMP) == $past(ctl.msb_flip && !ctl.low_flip)) &&
         ((out_format == fadm_pkg::FMT_INV_BIN) == $past(ctl.msb_flip && ctl.low_flip)))
      else $error("format code disagrees with flip controls");

   stack_msb_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      stack_a[fadm_pkg::STACK_W-1] == bank_a.ovf &&
         stack_b[fadm_pkg::STACK_W-2:0] == bank_b.data)
      else $error("stacked code does not place overflow on top");

   ovf_event_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(ovf_seen_reg ^ ovf_tog_f) |=> ovf_pulse ##1 !ovf_pulse)
      else $error("overflow event pulse not one cycle");

   bank_b_hold_a: assert property (
      @(posedge enc_clk) disable iff (!enc_rst_reg)
      load_b_s ##1 ctl.split |=> $stable(bank_b))
      else $error("split bank B changed before two encode cycles");

   ready_b_width_a: assert property (
      @(negedge enc_clk) disable iff (!enc_rst_reg)
      (ctl.split && $past(ctl.split) && !rdy_split_b_w && neg_valid_reg &&
         last_bank_reg == fadm_pkg::FADM_BANK_B) |=> ready_b_pulse_s)
      else $error("split ready B not high for exactly one encode cycle");

   ready_excl_a: assert property (
      @(negedge enc_clk) disable iff (!enc_rst_reg)
      !(rdy_a && rdy_b))
      else $error("both bank ready strobes high together");
endmodule

// [fadm_pkg.sv]
// Purpose: constants and types of the flash converter output stage; pin filter
// Assumes: comparator outputs are settled when the encode edge arrives
// Notes: the filter also carries the overflow toggle into the system clock
//
// Behaviour
// - every encode edge latches all 64 comparator outputs for decoding.
// - each bank carries six data bits plus one overflow bit.
// - overflow bit flags an input beyond positive full scale.
// - with two converters stacked, overflow acts as the 7-bit result MSB.
// - split variant sends successive words alternately to bank A and bank B.
// - one encode of pipeline delay; sample N appears after encode N+1.
// - sample of encode N-1 goes to bank B, sample N to bank A.
// - split variant holds each bank word for two whole encode cycles.
// - split bank ready rises after load-cycle midpoint, stays high one cycle.
// - single-port variant replaces its word at every encode.
// - single-port ready rises after midpoint, falls at the next encode.
// - msb flip control inverts data bit 5.
// - low bits flip control inverts data bits 4 down to 0.
`timescale 1ns/100ps

package fadm_pkg;
   localparam int COMP_COUNT = 64;
   localparam int DATA_W     = 6;
   localparam int LOW_W      = 5;
   localparam int MSB_POS    = 5;
   localparam int OVF_COMP   = 63;
   localparam int STACK_W    = 7;
   localparam int CTL_W      = 3;
   localparam int PIN_MSB    = 0;
   localparam int PIN_LOW    = 1;
   localparam int PIN_SPLIT  = 2;
   localparam logic [DATA_W-1:0] FULL_CODE = 6'h3F;
   localparam logic [CTL_W-1:0]  CTL_RST   = 3'h4;

   typedef struct packed {
      logic              ovf;
      logic [DATA_W-1:0] data;
   } fadm_word_t;

   typedef struct packed {
      logic split;
      logic low_flip;
      logic msb_flip;
   } fadm_ctl_t;

   typedef enum logic {
      FADM_BANK_A,
      FADM_BANK_B
   } fadm_bank_t;

   typedef enum logic [1:0] {
      FMT_OFFSET_BIN,
      FMT_TWOS_COMP,
      FMT_INV_TWOS,
      FMT_INV_BIN
   } fadm_fmt_t;

   localparam fadm_word_t WORD_RST = 7'h00;
endpackage

// three-stage filter; a change counts once stages two and three agree
module fadm_pin_sync #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] out_reg;
   logic [W-1:0] out_next;

   assign out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
   assign pin_out  = out_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_reg  <= RST;
         s2_reg  <= RST;
         s3_reg  <= RST;
         out_reg <= RST;
      end else begin
         s1_reg  <= pin_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end
endmodule

// [tb_flash_adc_output_demux.sv]
// Purpose: self-checking bench of the flash converter output stage
// Assumes: encode clock of 125 ns, phase unrelated to the 4 ns system clock
// Notes: reset is held over several encode edges so the encode domain clears
`timescale 1ns/100ps

module tb_flash_adc_output_demux;
   logic                      clk;
   logic                      rst_n;
   logic                      enc_clk;
   logic [63:0]               comp;
   logic                      msb_flip;
   logic                      low_flip;
   logic                      split;
   fadm_pkg::fadm_word_t      bank_a;
   fadm_pkg::fadm_word_t      bank_b;
   fadm_pkg::fadm_word_t      cap_a;
   fadm_pkg::fadm_word_t      cap_b;
   logic [6:0]                stack_a;
   logic [6:0]                stack_b;
   logic                      rdy_a;
   logic                      rdy_b;
   logic                      ovf_pulse;
   fadm_pkg::fadm_fmt_t       out_format;
   int                        fail_count;
   int                        cmp_count;
   int                        ovf_seen;
   fadm_pkg::fadm_word_t      exp_q[$];

   fadm_output_demux DUT (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .enc_clk               (enc_clk),
      .comp_in               (comp),
      .msb_flip_control      (msb_flip),
      .low_bits_flip_control (low_flip),
      .split_mode            (split),
      .bank_a                (bank_a),
      .bank_b                (bank_b),
      .stack_a               (stack_a),
      .stack_b               (stack_b),
      .rdy_a                 (rdy_a),
      .rdy_b                 (rdy_b),
      .out_format            (out_format),
      .ovf_pulse             (ovf_pulse)
   );

   fadm_capture capture (
      .rdy_a  (rdy_a),
      .rdy_b  (rdy_b),
      .bank_a (bank_a),
      .bank_b (bank_b),
      .cap_a  (cap_a),
      .cap_b  (cap_b)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      enc_clk = 1'b0;
      #37.3;
      forever #62.5 enc_clk = ~enc_clk;
   end

   always @(negedge clk) begin
      if (rst_n === 1'b1 && ovf_pulse === 1'b1) begin
         ovf_seen++;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         fail_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // independent decode: n ones in the thermometer, above 63 means overflow
   function automatic fadm_pkg::fadm_word_t expw(input int n, input logic m, input logic l);
      fadm_pkg::fadm_word_t w;
      w.ovf  = (n > 63);
      w.data = (n > 63) ? 6'h3F : n[5:0];
      w.data = w.data ^ {m, 5'h00} ^ {1'b0, {5{l}}};
      return w;
   endfunction

   task automatic set_mode(input logic s, input logic m, input logic l);
      @(posedge enc_clk);
      #1;
      split    = s;
      msb_flip = m;
      low_flip = l;
      repeat (6) @(posedge enc_clk);
      #1;
      check(out_format, {30'h0, l, m});
   endtask

   // one sample per encode; sel 1 marks bank B as the bank just loaded
   task automatic stream(input int vals[$], input logic s, input logic m, input logic l);
      logic sel;
      int   v;
      sel = 1'b0;
      exp_q.delete();
      for (int i = 0; i < vals.size() + 2; i++) begin
         @(posedge enc_clk);
         #1;
         if (i >= 3 && s) check(sel ? rdy_b : rdy_a, 1'b1);
         if (i >= 2) begin
            // equal bank contents leave the phase open; the older strobe still stands here
            if (i == 2) sel = s && (bank_a !== exp_q[0] || rdy_a === 1'b1);
            else sel = s & ~sel;
            check(sel ? bank_b : bank_a, exp_q[i-2]);
            check(sel ? stack_b : stack_a, exp_q[i-2]);
            if (i >= 3 && s) check(sel ? bank_a : bank_b, exp_q[i-3]);
            if (!s) check(rdy_a, 1'b0);
         end
         if (i < vals.size()) begin
            v    = vals[i];
            comp = (v > 63) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << v) - 64'h1;
            exp_q.push_back(expw(v, m, l));
         end else begin
            comp = 64'h0;
         end
         @(negedge enc_clk);
         #1;
         if (i >= 2 && s) begin
            check(sel ? rdy_b : rdy_a, 1'b1);
            check(sel ? rdy_a : rdy_b, 1'b0);
            check(sel ? cap_b : cap_a, exp_q[i-2]);
         end else if (i >= 2) begin
            check(rdy_a, 1'b1);
            check(rdy_b, 1'b0);
            check(cap_a, exp_q[i-2]);
         end
      end
   endtask

   task automatic test_split_formats();
      logic [1:0] f;
      for (int k = 0; k < 4; k++) begin
         f = k[1:0];
         set_mode(1'b1, f[0], f[1]);
         stream('{0, 63, 1, 62, 31, 32, 5}, 1'b1, f[0], f[1]);
      end
   endtask

   task automatic test_single();
      fadm_pkg::fadm_word_t held;
      set_mode(1'b0, 1'b1, 1'b0);
      held = bank_b;
      stream('{5, 6, 7, 0, 63, 40}, 1'b0, 1'b1, 1'b0);
      check(bank_b, held);
   endtask

   task automatic test_overflow();
      set_mode(1'b1, 1'b0, 1'b1);
      ovf_seen = 0;
      stream('{10, 64, 64, 20, 3}, 1'b1, 1'b0, 1'b1);
      repeat (3) @(posedge enc_clk);
      check(ovf_seen, 2);
   endtask

   initial begin
      fail_count = 0;
      cmp_count  = 0;
      ovf_seen   = 0;
      rst_n      = 1'b0;
      comp       = 64'h0;
      msb_flip   = 1'b0;
      low_flip   = 1'b0;
      split      = 1'b1;
      #500;
      @(posedge clk);
      #1;
      check(bank_a, 7'h00);
      check(rdy_a, 1'b0);
      rst_n = 1'b1;
      repeat (4) @(posedge enc_clk);
      test_split_formats();
      test_single();
      test_overflow();
      summarize();
   end

   // run needs about 13 us; a hang is cut well after that
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
endmodule
